// >>> hdl/loader_host.sv
// Host controller that drives the serial flash loader
`timescale 1ns/1ps
`include "loader_host_regs.svh"
module loader_host
  import loader_host_pkg::*;
#(
  parameter int BAUD_DIV = 64
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire loader_host_pkg::host_req_t req_i,
  input wire logic req_valid_i,
  output loader_host_pkg::host_rsp_t rsp_o,
  output logic uart_tx_o,
  input wire logic uart_rx_i,
  output logic ssi_clk_o,
  output logic ssi_mosi_o,
  input wire logic ssi_miso_i,
  output logic idle_o
);
  import loader_host_pkg::*;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_SYNC = 4'b0001,
    ST_SYNC_WAIT = 4'b0010,
    ST_LOAD = 4'b0011,
    ST_SEND = 4'b0100,
    ST_ANS = 4'b0101,
    ST_RSP_SIZE = 4'b0110,
    ST_RSP_BODY = 4'b0111,
    ST_REPLY = 4'b1000,
    ST_DONE = 4'b1001
  } state_t;
  state_t state, next_state;
  logic locked, next_locked, port_ssi, next_port_ssi;
  logic synced, next_synced;
  logic [7:0] idx, next_idx, rsize, next_rsize, rsum, next_rsum;
  logic [7:0] rchk, next_rchk, status, next_status;
  logic [7:0] pad, next_pad;
  logic [15:0] wait_cnt, next_wait_cnt;
  logic [7:0] tx_byte, next_tx_byte;
  logic tx_go, next_tx_go;
  host_req_t cur, next_cur;
  host_rsp_t rsp, next_rsp;
  logic idle, next_idle;
  host_byte_t f_in, f_out;
  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic phy_busy, rx_valid;
  logic [7:0] rx_data;
  logic sclk, mosi, utx;
  host_byte_fifo #(.WIDTH($bits(host_byte_t)), .DEPTH(8)) u_fifo (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .in_data_i(f_in),
    .in_valid_i(f_in_valid),
    .in_ready_o(f_in_ready),
    .out_data_o(f_out),
    .out_valid_o(f_out_valid),
    .out_ready_i(f_out_ready)
  );
  host_serial_phy #(.BAUD_DIV(BAUD_DIV)) u_phy (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .use_ssi_i(port_ssi),
    .tx_data_i(tx_byte),
    .tx_start_i(tx_go),
    .busy_o(phy_busy),
    .rx_data_o(rx_data),
    .rx_valid_o(rx_valid),
    .uart_tx_o(utx),
    .uart_rx_i(uart_rx_i),
    .ssi_clk_o(sclk),
    .ssi_mosi_o(mosi),
    .ssi_miso_i(ssi_miso_i)
  );
  //////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    next_locked = locked;
    next_port_ssi = port_ssi;
    next_synced = synced;
    next_idx = idx;
    next_rsize = rsize;
    next_rsum = rsum;
    next_rchk = rchk;
    next_status = status;
    next_pad = pad;
    next_wait_cnt = wait_cnt;
    next_tx_byte = tx_byte;
    next_tx_go = 1'b0;
    next_cur = cur;
    next_rsp = rsp;
    next_rsp.done = 1'b0;
    next_idle = 1'b0;
    f_in = '0;
    f_in_valid = 1'b0;
    f_out_ready = 1'b0;
    case (state)
      ST_IDLE: begin
        next_idle = 1'b1;
        if (req_valid_i) begin
          next_idle = 1'b0;
          next_cur = req_i;
          if (!locked) begin
            next_locked = 1'b1;
            next_port_ssi = req_i.use_ssi;
            next_cur.use_ssi = req_i.use_ssi;
          end
          next_idx = '0;
          if (!(locked ? port_ssi : req_i.use_ssi) && !synced) begin
            next_state = ST_SYNC;
          end else begin
            next_state = ST_LOAD;
          end
        end
      end
      ST_SYNC: begin
        if (!phy_busy && !tx_go) begin
          if (idx == 8'h02) begin
            next_state = ST_SYNC_WAIT;
            next_wait_cnt = '0;
          end else begin
            next_tx_byte = `SYNC_BYTE;
            next_tx_go = 1'b1;
            next_idx = idx + 8'h01;
          end
        end
      end
      ST_SYNC_WAIT: begin
        next_wait_cnt = wait_cnt + 16'h0001;
        if (rx_valid && rx_data == `ACK_BYTE) begin
          next_synced = 1'b1;
          next_idx = '0;
          next_state = ST_LOAD;
        end else if (wait_cnt == 16'(`SYNC_WAIT_BITS * BAUD_DIV)) begin
          next_idx = '0;
          next_state = ST_SYNC;
        end
      end
      ST_LOAD: begin
        f_in_valid = 1'b1;
        f_in.last = 1'b0;
        case (idx)
          8'h00: f_in.data = 8'h03;
          8'h01: f_in.data = cur.cmd;
          default: begin
            f_in.data = cur.cmd;
            f_in.last = 1'b1;
          end
        endcase
        if (f_in_ready) begin
          next_idx = idx + 8'h01;
          if (idx == 8'h02) begin
            next_state = ST_SEND;
          end
        end
      end
      ST_SEND: begin
        if (!phy_busy && !tx_go && f_out_valid) begin
          f_out_ready = 1'b1;
          next_tx_byte = f_out.data;
          next_tx_go = 1'b1;
          if (f_out.last) begin
            next_state = ST_ANS;
            next_pad = '0;
          end
        end
      end
      ST_ANS: begin
        if (port_ssi && !phy_busy && !tx_go) begin
          next_tx_byte = `ZERO_BYTE;
          next_tx_go = 1'b1;
        end
        if (rx_valid && rx_data != `ZERO_BYTE) begin
          next_rsp.ack = (rx_data == `ACK_BYTE);
          next_rsp.nak = (rx_data != `ACK_BYTE);
          if (rx_data != `ACK_BYTE) begin
            next_idx = '0;
            next_state = ST_LOAD;
          end else if (cur.cmd == `CMD_STATUS) begin
            next_state = ST_RSP_SIZE;
          end else begin
            next_state = ST_DONE;
          end
        end
      end
      ST_RSP_SIZE, ST_RSP_BODY: begin
        if (port_ssi && !phy_busy && !tx_go) begin
          next_tx_byte = `ZERO_BYTE;
          next_tx_go = 1'b1;
        end
        if (rx_valid) begin
          if (state == ST_RSP_SIZE) begin
            if (rx_data != `ZERO_BYTE) begin
              next_rsize = rx_data;
              next_idx = 8'h01;
              next_rsum = '0;
              next_state = ST_RSP_BODY;
            end
          end else begin
            next_idx = idx + 8'h01;
            if (idx == 8'h01) begin
              next_rchk = rx_data;
            end else begin
              next_rsum = rsum + rx_data;
              next_status = rx_data;
            end
            if (idx + 8'h01 == rsize) begin
              next_state = ST_REPLY;
            end
          end
        end
      end
      ST_REPLY: begin
        if (!phy_busy && !tx_go) begin
          next_tx_byte = (rsum == rchk) ? `ACK_BYTE : `NAK_BYTE;
          next_tx_go = 1'b1;
          if (rsum == rchk) begin
            next_state = ST_DONE;
          end else begin
            next_idx = '0;
            next_state = ST_LOAD;
          end
        end
      end
      ST_DONE: begin
        if (!phy_busy && !tx_go) begin
          next_rsp.done = 1'b1;
          next_rsp.status = status;
          next_rsp.synced = synced;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
      locked <= 1'b0;
      port_ssi <= 1'b0;
      synced <= 1'b0;
      idx <= '0;
      rsize <= '0;
      rsum <= '0;
      rchk <= '0;
      status <= '0;
      pad <= '0;
      wait_cnt <= '0;
      tx_byte <= '0;
      tx_go <= 1'b0;
      cur <= '0;
      rsp <= '0;
      idle <= 1'b0;
      uart_tx_o <= 1'b1;
      ssi_clk_o <= 1'b1;
      ssi_mosi_o <= 1'b1;
    end else begin
      state <= next_state;
      locked <= next_locked;
      port_ssi <= next_port_ssi;
      synced <= next_synced;
      idx <= next_idx;
      rsize <= next_rsize;
      rsum <= next_rsum;
      rchk <= next_rchk;
      status <= next_status;
      pad <= next_pad;
      wait_cnt <= next_wait_cnt;
      tx_byte <= next_tx_byte;
      tx_go <= next_tx_go;
      cur <= next_cur;
      rsp <= next_rsp;
      idle <= next_idle;
      uart_tx_o <= utx;
      ssi_clk_o <= sclk;
      ssi_mosi_o <= mosi;
    end
  end
  assign rsp_o = rsp;
  assign idle_o = idle;
  //////////////////////////////////////////////////////////////////////
  AST_PORT_LOCK: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    locked && $past(locked) |-> port_ssi == $past(port_ssi))
    else $error("port changed after lock");
  AST_SYNC_BYTE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    tx_go && state == ST_SYNC |-> tx_byte == `SYNC_BYTE)
    else $error("sync byte wrong");
  AST_SYNC_FIRST: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state == ST_LOAD && !port_ssi |-> synced)
    else $error("packet before baud sync");
  AST_NAK_RETRY: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state == ST_ANS && rx_valid && rx_data != `ZERO_BYTE &&
    rx_data != `ACK_BYTE |=> state == ST_LOAD)
    else $error("no resend after nak");
  AST_ZERO_SKIP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state == ST_ANS && rx_valid && rx_data == `ZERO_BYTE |=>
    state == ST_ANS)
    else $error("zero byte taken as answer");
  AST_SIZE_BYTE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state == ST_LOAD && idx == 8'h00 |-> f_in.data == 8'h03)
    else $error("size byte wrong");
  AST_CHECKSUM: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state == ST_LOAD && idx == 8'h01 |-> f_in.data == cur.cmd)
    else $error("checksum byte wrong");
  AST_REPLY: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state == ST_REPLY && !phy_busy && !tx_go |=> tx_go &&
    ((tx_byte == `ACK_BYTE) == $past(rsum == rchk)))
    else $error("reply mismatch");
  COV_PING: cover property (@(posedge clk_i) rsp.done && rsp.ack);
  COV_NAK: cover property (@(posedge clk_i) rsp.nak);
  COV_STATUS: cover property (@(posedge clk_i) state == ST_REPLY);
endmodule

// >>> common/loader_host_regs.svh
// Constants for the serial loader host controller
`ifndef LOADER_HOST_REGS_SVH
`define LOADER_HOST_REGS_SVH
`define SYNC_BYTE 8'h55
`define ACK_BYTE 8'hCC
`define NAK_BYTE 8'h33
`define CMD_PING 8'h20
`define CMD_STATUS 8'h23
`define ZERO_BYTE 8'h00
`define PKT_OVERHEAD 8'h02
`define BYTE_BITS 4'h8
`define UART_FRAME_BITS 4'h9
`define SSI_DIV_HALF 8'h06
`define SYNC_WAIT_BITS 16'h0028
`define SSI_BYTE_BITS 4'h8
`define PAD_LIMIT 8'hFF
`endif

// >>> common/loader_host_pkg.sv
// Types shared by the loader host controller
package loader_host_pkg;
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } host_byte_t;
  typedef struct packed {
    logic use_ssi;
    logic [7:0] cmd;
    logic [7:0] arg_count;
  } host_req_t;
  typedef struct packed {
    logic done;
    logic ack;
    logic nak;
    logic synced;
    logic [7:0] status;
  } host_rsp_t;
endpackage

// >>> hdl/host_byte_fifo.sv
// Byte FIFO for outbound packet data
`timescale 1ns/1ps
module host_byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic do_wr, do_rd;
  always_comb begin
    do_wr = in_valid_i && in_ready_o;
    do_rd = out_valid_o && out_ready_i;
    next_wr_ptr = wr_ptr + (AW+1)'(do_wr);
    next_rd_ptr = rd_ptr + (AW+1)'(do_rd);
    in_ready_o = !((wr_ptr[AW] != rd_ptr[AW]) &&
      (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    out_valid_o = (wr_ptr != rd_ptr);
    out_data_o = mem[rd_ptr[AW-1:0]];
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end
  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
endmodule

// >>> hdl/host_serial_phy.sv
// Byte-level UART and SPI mode 3 master for the host
`timescale 1ns/1ps
`include "loader_host_regs.svh"
module host_serial_phy #(
  parameter int BAUD_DIV = 64
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic use_ssi_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_start_i,
  output logic busy_o,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic uart_tx_o,
  input wire logic uart_rx_i,
  output logic ssi_clk_o,
  output logic ssi_mosi_o,
  input wire logic ssi_miso_i
);
  logic [1:0] rx_sync, miso_sync;
  logic [15:0] cnt, next_cnt;
  logic [3:0] bitn, next_bitn;
  logic [9:0] sh, next_sh;
  logic [7:0] rsh, next_rsh;
  logic tbusy, next_tbusy, rbusy, next_rbusy;
  logic [15:0] rcnt, next_rcnt;
  logic [3:0] rbit, next_rbit;
  logic next_sclk, next_rxv;
  logic [7:0] next_rxd;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_sync <= 2'b11;
      miso_sync <= 2'b11;
    end else begin
      rx_sync <= {rx_sync[0], uart_rx_i};
      miso_sync <= {miso_sync[0], ssi_miso_i};
    end
  end
  always_comb begin
    next_cnt = cnt;
    next_bitn = bitn;
    next_sh = sh;
    next_rsh = rsh;
    next_tbusy = tbusy;
    next_sclk = ssi_clk_o;
    next_rbusy = rbusy;
    next_rcnt = rcnt;
    next_rbit = rbit;
    next_rxv = 1'b0;
    next_rxd = rx_data_o;
    if (tx_start_i && !tbusy) begin
      next_tbusy = 1'b1;
      next_cnt = '0;
      next_bitn = '0;
      next_sh = use_ssi_i ? {2'b11, tx_data_i} : {1'b1, tx_data_i, 1'b0};
    end else if (tbusy && !use_ssi_i) begin
      next_cnt = cnt + 16'h0001;
      if (cnt == 16'(BAUD_DIV - 1)) begin
        next_cnt = '0;
        next_sh = {1'b1, sh[9:1]};
        next_bitn = bitn + 4'h1;
        if (bitn == `UART_FRAME_BITS) begin
          next_tbusy = 1'b0;
        end
      end
    end else if (tbusy) begin
      next_cnt = cnt + 16'h0001;
      if (cnt[7:0] == `SSI_DIV_HALF - 8'h01) begin
        next_cnt = '0;
        next_sclk = !ssi_clk_o;
        if (ssi_clk_o) begin
          // Shift on falling edge, away from sampling edge
          if (bitn != 4'h0) begin
            next_sh = {sh[8:0], 1'b1};
          end
        end else begin
          next_rsh = {rsh[6:0], miso_sync[1]};
          next_bitn = bitn + 4'h1;
          if (bitn == `SSI_BYTE_BITS - 4'h1) begin
            next_tbusy = 1'b0;
            next_rxv = 1'b1;
            next_rxd = {rsh[6:0], miso_sync[1]};
          end
        end
      end
    end
    if (!use_ssi_i) begin
      if (!rbusy && !rx_sync[1]) begin
        next_rbusy = 1'b1;
        next_rcnt = 16'(BAUD_DIV / 2);
        next_rbit = '0;
      end else if (rbusy) begin
        next_rcnt = rcnt + 16'h0001;
        if (rcnt == 16'(BAUD_DIV - 1)) begin
          next_rcnt = '0;
          next_rbit = rbit + 4'h1;
          if (rbit == `BYTE_BITS + 4'h1) begin
            next_rbusy = 1'b0;
          end else if (rbit != 4'h0) begin
            next_rsh = {rx_sync[1], rsh[7:1]};
            if (rbit == `BYTE_BITS) begin
              next_rxv = 1'b1;
              next_rxd = {rx_sync[1], rsh[7:1]};
            end
          end
        end
      end
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt <= '0;
      bitn <= '0;
      sh <= 10'h3FF;
      rsh <= '0;
      tbusy <= 1'b0;
      ssi_clk_o <= 1'b1;
      rbusy <= 1'b0;
      rcnt <= '0;
      rbit <= '0;
      rx_valid_o <= 1'b0;
      rx_data_o <= '0;
    end else begin
      cnt <= next_cnt;
      bitn <= next_bitn;
      sh <= next_sh;
      rsh <= next_rsh;
      tbusy <= next_tbusy;
      ssi_clk_o <= next_sclk;
      rbusy <= next_rbusy;
      rcnt <= next_rcnt;
      rbit <= next_rbit;
      rx_valid_o <= next_rxv;
      rx_data_o <= next_rxd;
    end
  end
  assign busy_o = tbusy;
  assign uart_tx_o = use_ssi_i ? 1'b1 : sh[0];
  assign ssi_mosi_o = sh[7];
endmodule

// >>> tb/loader_device_model.sv
// Behavioural model of the serial loader device
`timescale 1ns/1ps
`include "loader_host_regs.svh"
module loader_device_model #(
  parameter real XTAL_NS = 8.0,
  parameter logic [7:0] STATUS_OK = 8'h40,
  parameter logic [7:0] STATUS_BAD_CMD = 8'h41
) (
  input wire logic reset_n_i,
  input wire logic uart_rx_i,
  output logic uart_tx_o = 1'b1,
  input wire logic ssi_clk_i,
  input wire logic ssi_mosi_i,
  output logic ssi_miso_o = 1'b1
);
  int port = 0, synced = 0, bit_n = 0;
  int drop_sync = 0, nak_pkts = 0, bad_ck = 0, pad = 0;
  int sync_pairs = 0, pkts = 0, host_naks = 0;
  int uart_bytes = 0, ssi_bytes = 0, faults = 0;
  real bit_t = 1000.0, t0 = 0.0, t_fall = 0.0;
  logic [7:0] status = 8'h00;
  logic [7:0] rx_sh, ssi_sh, tx_sh;
  logic [7:0] rxq[$], txq[$];

  ////////////////////////////////////////////////////////////////////////
  task automatic get_b(output logic [7:0] b);
    wait (rxq.size() > 0);
    b = rxq.pop_front();
  endtask

  task automatic send_b(input logic [7:0] b);
    if (port == 2) begin
      txq.push_back(b);
    end else begin
      uart_tx_o = 1'b0;
      #(bit_t);
      for (int i = 0; i < 8; i++) begin
        uart_tx_o = b[i];
        #(bit_t);
      end
      uart_tx_o = 1'b1;
      #(bit_t);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // device reset frees the port
  always @(negedge reset_n_i) begin
    disable eng;
    disable urx;
    port = 0;
    synced = 0;
    bit_n = 0;
    status = 8'h00;
    rxq.delete();
    txq.delete();
    uart_tx_o = 1'b1;
  end

  always begin : urx
    @(negedge uart_rx_i);
    t0 = $realtime;
    if (!synced) begin
      @(posedge uart_rx_i);
      bit_t = $realtime - t0;
      if (bit_t < 32.0 * XTAL_NS) faults++;
    end
    #(t0 + 1.5 * bit_t - $realtime);
    for (int i = 0; i < 8; i++) begin
      rx_sh[i] = uart_rx_i;
      #(bit_t);
    end
    if (uart_rx_i !== 1'b1) faults++;
    uart_bytes++;
    if (port != 2) begin
      port = 1;
      rxq.push_back(rx_sh);
    end
  end

  // mode 3, drive on falling edge
  always @(negedge ssi_clk_i) begin
    t_fall = $realtime;
    if (bit_n == 0) tx_sh = (port == 2 && txq.size() > 0) ? txq.pop_front() : 8'h00;
    ssi_miso_o = tx_sh[7 - bit_n];
  end

  // sample on rising edge, clock limit
  always @(posedge ssi_clk_i) begin
    if (reset_n_i === 1'b1 && t_fall > 0.0) begin
      if ($realtime - t_fall < 6.0 * XTAL_NS) faults++;
      ssi_sh[7 - bit_n] = ssi_mosi_i;
      bit_n = (bit_n + 1) % 8;
      if (bit_n == 0) begin
        ssi_bytes++;
        if (port != 1) begin
          port = 2;
          rxq.push_back(ssi_sh);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always begin : eng
    logic [7:0] b, b2, ck, cmd, sum;
    get_b(b);
    if (port == 1 && !synced) begin
      get_b(b2);
      if (b == `SYNC_BYTE && b2 == `SYNC_BYTE) begin
        sync_pairs++;
        if (drop_sync > 0) drop_sync--;
        else begin
          synced = 1;
          send_b(`ACK_BYTE);
        end
      end
    end else if (b != `ZERO_BYTE) begin
      get_b(ck);
      sum = 8'h00;
      cmd = 8'h00;
      for (int i = 0; i < int'(b) - 2; i++) begin
        get_b(b2);
        if (i == 0) cmd = b2;
        sum += b2;
      end
      pkts++;
      repeat (pad) send_b(`ZERO_BYTE);
      if (nak_pkts > 0 || ck != sum) begin
        if (nak_pkts > 0) nak_pkts--;
        send_b(`NAK_BYTE);
      end else begin
        send_b(`ACK_BYTE);
        if (cmd == `CMD_PING) status = STATUS_OK;
        else if (cmd == `CMD_STATUS) begin
          repeat (pad) send_b(`ZERO_BYTE);
          send_b(8'h03);
          send_b(bad_ck > 0 ? ~status : status);
          send_b(status);
          if (bad_ck > 0) bad_ck--;
          b2 = `ZERO_BYTE;
          while (b2 == `ZERO_BYTE) get_b(b2);
          if (b2 == `NAK_BYTE) host_naks++;
          else if (b2 != `ACK_BYTE) faults++;
        end else status = STATUS_BAD_CMD;
      end
    end
  end
endmodule

// >>> tb/loader_host_test.sv
// Self-checking bench for the loader host controller
`timescale 1ns/1ps
`include "loader_host_regs.svh"
module loader_host_test;
  import loader_host_pkg::*;
  localparam logic [7:0] ST_OK = 8'h40;
  localparam logic [7:0] ST_BAD = 8'h41;
  typedef struct {
    logic rst, use_ssi;
    logic [7:0] cmd;
    int drop, nak, bad, pad;
    logic [7:0] exp_status;
  } row_t;
  row_t rows[7] = '{
    '{0, 0, `CMD_PING, 1, 0, 0, 0, ST_OK},
    '{0, 0, `CMD_STATUS, 0, 0, 0, 2, ST_OK},
    '{0, 0, 8'h5A, 0, 1, 0, 0, ST_BAD},
    '{0, 0, `CMD_STATUS, 0, 0, 1, 1, ST_BAD},
    '{1, 1, `CMD_PING, 0, 1, 0, 0, ST_OK},
    '{0, 1, `CMD_STATUS, 0, 0, 0, 3, ST_OK},
    '{0, 1, `CMD_STATUS, 0, 0, 1, 0, ST_OK}
  };
  logic clk = 1'b0, reset_n = 1'b0, req_valid = 1'b0;
  host_req_t req = '0;
  host_rsp_t rsp;
  logic host_tx, host_rx, sck, mosi, miso, idle;
  int errors = 0, checks_done = 0;
  int hn, pk, sp;

  always #4 clk = ~clk;

  loader_host #(.BAUD_DIV(32)) dut (
    .clk_i(clk), .reset_n_i(reset_n), .req_i(req),
    .req_valid_i(req_valid), .rsp_o(rsp), .uart_tx_o(host_tx),
    .uart_rx_i(host_rx), .ssi_clk_o(sck), .ssi_mosi_o(mosi),
    .ssi_miso_i(miso), .idle_o(idle)
  );
  loader_device_model #(.STATUS_OK(ST_OK), .STATUS_BAD_CMD(ST_BAD)) model (
    .reset_n_i(reset_n), .uart_rx_i(host_tx), .uart_tx_o(host_rx),
    .ssi_clk_i(sck), .ssi_mosi_i(mosi), .ssi_miso_o(miso)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic fail(input string msg);
    errors++;
    $display("ERROR at %0t: %s", $time, msg);
  endtask
  task automatic check1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) fail($sformatf("flag %b expected %b", got, exp));
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) fail($sformatf("byte %h expected %h", got, exp));
  endtask
  task automatic checkn(input int got, input int exp);
    checks_done++;
    if (got != exp) fail($sformatf("count %0d expected %0d", got, exp));
  endtask
  task automatic do_reset();
    @(negedge clk);
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
  endtask
  task automatic start_req(input logic ssi, input logic [7:0] cmd);
    int n;
    n = 0;
    while (idle !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    req = '{use_ssi: ssi, cmd: cmd, arg_count: 8'h00};
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (rsp.done !== 1'b1 && n < 30000) begin
      @(negedge clk);
      n++;
    end
    check1(rsp.done, 1'b1);
  endtask
  task automatic end_of_test();
    $display("Checks: %0d, errors: %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #(90000 * 8);
    fail("watchdog expired");
    end_of_test();
  end

  initial begin
    @(negedge clk);
    check1(host_tx, 1'b1);
    check1(sck, 1'b1);
    check1(rsp.ack, 1'b0);
    @(negedge clk);
    reset_n = 1'b1;
    foreach (rows[i]) begin
      if (rows[i].rst) do_reset();
      model.drop_sync = rows[i].drop;
      model.nak_pkts = rows[i].nak;
      model.bad_ck = rows[i].bad;
      model.pad = rows[i].pad;
      hn = model.host_naks;
      pk = model.pkts;
      start_req(rows[i].use_ssi, rows[i].cmd);
      wait_done();
      check1(rsp.ack, 1'b1);
      check1(rsp.nak, 1'b0);
      checkn(model.pkts - pk, 1 + rows[i].nak + rows[i].bad);
      checkn(model.host_naks - hn, rows[i].bad);
      if (rows[i].cmd == `CMD_STATUS)
        check8(rsp.status, rows[i].exp_status);
      if (!rows[i].use_ssi) check1(rsp.synced, 1'b1);
    end
    checkn(model.sync_pairs, 2);
    // Locked to the SSI port, a uart request stays on it
    sp = model.uart_bytes;
    start_req(1'b0, `CMD_PING);
    wait_done();
    checkn(model.uart_bytes - sp, 0);
    // Reset in mid-sync, then a fresh uart session
    do_reset();
    start_req(1'b0, `CMD_PING);
    repeat (500) @(negedge clk);
    do_reset();
    check1(host_tx, 1'b1);
    check1(rsp.ack, 1'b0);
    sp = model.ssi_bytes;
    start_req(1'b0, `CMD_PING);
    wait_done();
    check1(rsp.ack, 1'b1);
    checkn(model.sync_pairs, 3);
    start_req(1'b1, `CMD_PING);
    wait_done();
    checkn(model.ssi_bytes - sp, 0);
    checkn(model.faults, 0);
    end_of_test();
  end
endmodule
